// ==== umw_pkg.sv ====
package umw_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0]  UMW_OFF_SETUP_LO = 8'h34;
    localparam logic [7:0]  UMW_OFF_SETUP_HI = 8'h38;
    localparam logic [7:0]  UMW_OFF_BASE_LO  = 8'h60;
    localparam logic [7:0]  UMW_OFF_BASE_HI  = 8'h64;
    localparam logic [7:0]  UMW_OFF_CTRL     = 8'h68;
    localparam logic [7:0]  UMW_OFF_STAT     = 8'h7C;
    // field positions and values
    localparam int          UMW_EN_BIT       = 31;
    localparam int          UMW_ADDR64_BIT   = 21;
    localparam int          UMW_PAGE_LSB     = 12;
    localparam int          UMW_TYPE_LSB     = 1;
    localparam int          UMW_PREF_BIT     = 3;
    localparam int          UMW_SPACE_BIT    = 0;
    localparam int          UMW_ST_HIT       = 0;
    localparam int          UMW_ST_FWD       = 1;
    localparam int          UMW_ST_ACTIVE    = 2;
    localparam logic [31:0] UMW_BASE_LO_MASK = 32'hFFFFF000;
    localparam logic [31:0] UMW_ZERO32       = 32'h00000000;
    localparam logic [1:0]  UMW_TYPE_32      = 2'b00;
    localparam logic [1:0]  UMW_TYPE_64      = 2'b01;
    localparam logic        UMW_MEM_SPACE    = 1'b0;
    localparam logic        UMW_NON_PREF     = 1'b0;
endpackage

// ==== umw_decode.sv ====
module umw_decode
    import umw_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // window setup
    input  wire logic        win_en,
    input  wire logic [63:0] win_base,
    input  wire logic [63:0] win_mask,
    // secondary bus address phase
    input  wire logic        sec_valid,
    input  wire logic        sec_dac,
    input  wire logic [63:0] sec_addr,
    // decode result
    output logic             hit_q,
    output logic             fwd_q
);
    typedef struct packed {
        logic hit;
        logic fwd;
    } umw_dec_t;

    umw_dec_t   st_q;
    umw_dec_t   st_d;
    logic [63:0] addr_full;
    logic        match;

    always_comb begin
        st_d      = st_q;
        addr_full = sec_dac ? sec_addr : {UMW_ZERO32, sec_addr[31:0]};
        match     = ((addr_full ^ win_base) & win_mask) == {UMW_ZERO32, UMW_ZERO32};
        st_d.hit  = sec_valid & win_en & match;
        st_d.fwd  = sec_valid & sec_dac & ~(win_en & match);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit_q = st_q.hit;
    assign fwd_q = st_q.fwd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_hit_needs_en: assert property (hit_q |-> $past(win_en) && $past(sec_valid))
        else $error("hit without enabled window");
    a_fwd_dac_miss: assert property (sec_valid && sec_dac && !win_en |=> fwd_q && !hit_q)
        else $error("miss on dac not forwarded");
    a_hit_excl_fwd: assert property (!(hit_q && fwd_q))
        else $error("hit and forward together");
endmodule // umw_decode

// ==== umw_top.sv ====
// What this block does
// - address type read-only, 00 or 01
// - bit0 memory, bit3 non-prefetchable, read zero
// - low register bits 31:12 hold base
// - low setup register selects writable base bits
// - setup bit31 zero disables the window
// - 64-bit addressing joins both base registers
// - no translation when 64-bit addressing off
// - dac misses forwarded upstream
// - upper register holds upper 32 bits
module umw_top
    import umw_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // secondary bus address phase
    input  wire logic        sec_valid,
    input  wire logic        sec_dac,
    input  wire logic [63:0] sec_addr,
    // decode result
    output logic             win_hit,
    output logic             win_fwd
);
    typedef struct packed {
        logic [31:0] setup_lo;
        logic [31:0] setup_hi;
        logic [31:0] base_lo;
        logic [31:0] base_hi;
        logic        addr64;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } umw_state_t;

    umw_state_t  st_q;
    umw_state_t  st_d;
    logic        rst_s1_q;
    logic        rst_n_q;
    logic [31:0] be_mask;
    logic [31:0] lo_wmask;
    logic [31:0] base_lo_eff;
    logic [31:0] base_hi_eff;
    logic [31:0] base_lo_rd;
    logic [31:0] stat_rd;
    logic        win_en;
    logic        wr_take;
    logic        dec_hit;
    logic        dec_fwd;

    // reset release through two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // byte lane mask from strobes
    for (genvar b = 0; b < 4; b++) begin : g_be
        assign be_mask[b*8 +: 8] = {8{pstrb[b]}};
    end

    // writable bits of the low base follow the low setup register
    assign lo_wmask    = st_q.setup_lo & UMW_BASE_LO_MASK;
    assign base_lo_eff = st_q.base_lo & lo_wmask;
    assign base_hi_eff = st_q.base_hi & st_q.setup_hi;
    assign win_en      = st_q.setup_lo[UMW_EN_BIT] & st_q.setup_hi[UMW_EN_BIT]
                       & st_q.addr64;

    always_comb begin
        base_lo_rd = base_lo_eff;
        base_lo_rd[UMW_SPACE_BIT] = UMW_MEM_SPACE;
        base_lo_rd[UMW_PREF_BIT]  = UMW_NON_PREF;
        base_lo_rd[UMW_TYPE_LSB +: 2] = st_q.addr64 ? UMW_TYPE_64 : UMW_TYPE_32;
        stat_rd = UMW_ZERO32;
        stat_rd[UMW_ST_HIT]    = win_hit;
        stat_rd[UMW_ST_FWD]    = win_fwd;
        stat_rd[UMW_ST_ACTIVE] = win_en;
    end

    assign wr_take = psel & penable & st_q.ready & pwrite;

    always_comb begin
        st_d = st_q;
        // zero-wait answer: ready and read data set in the setup cycle
        st_d.ready  = psel & ~penable;
        st_d.slverr = 1'b0;
        if (psel && !penable) begin
            st_d.rdata = UMW_ZERO32;
            case (paddr)
                UMW_OFF_SETUP_LO: st_d.rdata = st_q.setup_lo;
                UMW_OFF_SETUP_HI: st_d.rdata = st_q.setup_hi;
                UMW_OFF_BASE_LO:  st_d.rdata = base_lo_rd;
                UMW_OFF_BASE_HI:  st_d.rdata = base_hi_eff;
                UMW_OFF_CTRL: begin
                    st_d.rdata[UMW_ADDR64_BIT] = st_q.addr64;
                end
                UMW_OFF_STAT:     st_d.rdata = stat_rd;
                default:          st_d.slverr = 1'b1;
            endcase
        end
        if (wr_take) begin
            case (paddr)
                UMW_OFF_SETUP_LO: begin
                    st_d.setup_lo = (st_q.setup_lo & ~be_mask) | (pwdata & be_mask);
                    // bits that become locked are cleared so they stay zero later
                    st_d.base_lo  = st_q.base_lo & st_d.setup_lo & UMW_BASE_LO_MASK;
                end
                UMW_OFF_SETUP_HI: begin
                    st_d.setup_hi = (st_q.setup_hi & ~be_mask) | (pwdata & be_mask);
                    st_d.base_hi  = st_q.base_hi & st_d.setup_hi;
                end
                UMW_OFF_BASE_LO: begin
                    st_d.base_lo = ((st_q.base_lo & ~be_mask) | (pwdata & be_mask)) & lo_wmask;
                end
                UMW_OFF_BASE_HI: begin
                    st_d.base_hi = ((st_q.base_hi & ~be_mask) | (pwdata & be_mask)) & st_q.setup_hi;
                end
                UMW_OFF_CTRL: begin
                    if (pstrb[UMW_ADDR64_BIT / 8]) begin
                        st_d.addr64 = pwdata[UMW_ADDR64_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.rdata;
    assign pready  = st_q.ready;
    assign pslverr = st_q.slverr;

    umw_decode u_decode (
        .clk       (mclk),
        .rst_n     (rst_n_q),
        .win_en    (win_en),
        .win_base  ({base_hi_eff, base_lo_eff}),
        .win_mask  ({st_q.setup_hi, lo_wmask}),
        .sec_valid (sec_valid),
        .sec_dac   (sec_dac),
        .sec_addr  (sec_addr),
        .hit_q     (dec_hit),
        .fwd_q     (dec_fwd)
    );

    assign win_hit = dec_hit;
    assign win_fwd = dec_fwd;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_q);

    sequence s_setup(logic [7:0] a);
        psel && !penable && paddr == a && !pwrite;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_type_field: assert property (s_setup(UMW_OFF_BASE_LO) ##1 s_access
        |-> prdata[2:1] == ($past(st_q.addr64) ? 2'b01 : 2'b00))
        else $error("address type field wrong");
    a_space_pref: assert property (s_setup(UMW_OFF_BASE_LO) ##1 s_access
        |-> !prdata[0] && !prdata[3])
        else $error("space or prefetch bit not zero");
    a_low_resv: assert property (s_setup(UMW_OFF_BASE_LO) ##1 s_access
        |-> prdata[11:4] == 8'h00)
        else $error("reserved bits not zero");
    a_low_locked: assert property ((st_q.base_lo & ~(st_q.setup_lo & 32'hFFFFF000)) == 32'h00000000
        || $changed(st_q.setup_lo))
        else $error("locked base bit set");
    a_low_write: assert property (wr_take && paddr == 8'h60 && pstrb == 4'hF
        |=> st_q.base_lo == ($past(pwdata) & $past(st_q.setup_lo) & 32'hFFFFF000))
        else $error("base low write wrong");
    a_high_write: assert property (wr_take && paddr == 8'h64 && pstrb == 4'hF
        |=> st_q.base_hi == ($past(pwdata) & $past(st_q.setup_hi)))
        else $error("base high write wrong");
    a_disabled_nohit: assert property (!st_q.setup_lo[31] || !st_q.setup_hi[31]
        |=> !win_hit)
        else $error("hit while disabled");
    a_no64_nohit: assert property (!st_q.addr64 ##1 !st_q.addr64 |-> !win_hit)
        else $error("hit with 64-bit addressing off");
    a_full_match: assert property (win_en && sec_valid && sec_dac
        && sec_addr[63:12] == {base_hi_eff, base_lo_eff[31:12]} |=> win_hit && !win_fwd)
        else $error("exact base not hit");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb ready timing wrong");
endmodule // umw_top

// ==== umw_sec_agent.sv ====
module umw_sec_agent (
    // clock
    input  wire logic        clk,
    // decode result
    input  wire logic        win_hit,
    input  wire logic        win_fwd,
    // address phase
    output logic             sec_valid,
    output logic             sec_dac,
    output logic [63:0]      sec_addr
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sec_valid = 1'b0;
        sec_dac   = 1'b0;
        sec_addr  = 64'h0;
    end

    // one address phase, then the bus shows the inverse of what was driven
    task automatic issue(input logic [63:0] a, input logic d, output logic h, output logic f);
        @(posedge clk);
        sec_valid <= 1'b1;
        sec_dac   <= d;
        sec_addr  <= a;
        @(posedge clk);
        sec_valid <= 1'b0;
        sec_dac   <= ~d;
        sec_addr  <= ~a;
        #1;
        h = win_hit;
        f = win_fwd;
    endtask
endmodule // umw_sec_agent

// ==== umw_tb.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import umw_pkg::*;

    logic        mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, sec_valid, sec_dac, win_hit, win_fwd, e, h, f;
    logic [63:0] sec_addr;
    logic [63:0] ad = {32'h12345678, 32'hFFFF0ABC};
    int          n_mismatch = 0, num_checks = 0;

    always #2.5 mclk = ~mclk;

    umw_top umw_top_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sec_valid(sec_valid), .sec_dac(sec_dac), .sec_addr(sec_addr), .win_hit(win_hit), .win_fwd(win_fwd));
    umw_sec_agent umw_sec_agent_i (.clk(mclk), .win_hit(win_hit), .win_fwd(win_fwd),
        .sec_valid(sec_valid), .sec_dac(sec_dac), .sec_addr(sec_addr));

    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        num_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, pready, 1'b1);
        end
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, e);
        chk({63'h0, e}, 64'h0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd, e);
        chk({e, rd}, {1'b0, x});
    endtask

    task automatic dec(input logic [63:0] a, input logic d, input logic xh, input logic xf);
        umw_sec_agent_i.issue(a, d, h, f);
        chk({h, f}, {xh, xf});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #50000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rdc(UMW_OFF_BASE_LO, 32'h00000000);
        rdc(UMW_OFF_BASE_HI, 32'h00000000);
        $display("test reset values done");
        wr(UMW_OFF_SETUP_HI, 32'hFFFFFFFF);
        wr(UMW_OFF_SETUP_LO, 32'hFFFFF000);
        wr(UMW_OFF_BASE_LO, 32'hFFFFFFFF);
        rdc(UMW_OFF_BASE_LO, 32'hFFFFF000);
        wr(UMW_OFF_SETUP_LO, 32'hFFFF0000);
        rdc(UMW_OFF_BASE_LO, 32'hFFFF0000);
        $display("test base fields done");
        dec(ad, 1'b1, 1'b0, 1'b1);
        wr(UMW_OFF_CTRL, 32'h00200000);
        rdc(UMW_OFF_BASE_LO, 32'hFFFF0002);
        wr(UMW_OFF_BASE_HI, 32'h12345678);
        rdc(UMW_OFF_BASE_HI, 32'h12345678);
        dec(ad, 1'b1, 1'b1, 1'b0);
        dec(ad ^ 64'h0000000100000000, 1'b1, 1'b0, 1'b1);
        dec(ad ^ 64'h0000000000010000, 1'b1, 1'b0, 1'b1);
        dec(ad ^ 64'h0000000000008000, 1'b1, 1'b1, 1'b0);
        dec(ad, 1'b0, 1'b0, 1'b0);
        rdc(UMW_OFF_CTRL, 32'h00200000);
        rdc(UMW_OFF_STAT, 32'h00000004);
        $display("test decode done");
        wr(UMW_OFF_SETUP_HI, 32'h7FFFFFFF);
        dec(ad, 1'b1, 1'b0, 1'b1);
        wr(UMW_OFF_SETUP_HI, 32'hFFFFFFFF);
        wr(UMW_OFF_SETUP_LO, 32'h7FFF0000);
        dec(ad, 1'b1, 1'b0, 1'b1);
        $display("test disable done");
        apb(1'b0, 8'h40, 32'h0, rd, e);
        chk({e, rd}, {1'b1, 32'h00000000});
        $display("test unmapped done");
        final_report();
    end
endmodule // testbench
